// [hdl/tcc_core.sv]
// control, event and status logic around three analog comparators
//
// Behaviour
// - event sets event_flag; further events and interrupts blocked until software clears it
// - compare_result is raw comparison, reversed when output_invert is set
// - edge select 11 raises event on any result change while flag is clear
// - edge select 10: falling edge, or rising edge when inverted
// - edge select 01: rising edge, or falling edge when inverted
// - non-inverting input from internal reference when bit 4 set, else pin a
// - inverting input 00 pin b, 01 pin c, 10 pin d, 11 bandgap tap
// - unit control bits 3 and 2 read zero and ignore writes
// - idle_halt stops all comparators while the device is idle
// - status bits 8 to 10 mirror event flags of units 1 to 3
// - status bits 0 to 2 mirror compare results of units 1 to 3
// - status bits 14 to 11 and 7 to 3 read zero, not writable
// - reference has two ranges of 16 levels, range bit 5, level code
// - bit 4 selects supply rails or external reference pins for the ladder
// - ref_pin_select acts only when noninv_input_select is set
// - bandgap tap 00 full, 01 half, 10 sixth, 11 pin
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "tcc_regs.svh"
`default_nettype none
module tcc_core
    import tcc_pkg::*;
#(
    parameter int UNITS = 3
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    input  wire logic [7:0]       addr_i,
    input  wire logic [31:0]      wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [31:0]      rdata_o,
    input  wire logic             device_idle_i,
    input  wire logic [UNITS-1:0] analog_cmp_i,
    output logic      [UNITS-1:0] unit_enable_o,
    output logic      [UNITS-1:0] noninv_sel_ref_o,
    output logic      [UNITS-1:0] noninv_use_ref_pin_o,
    output logic      [2*UNITS-1:0] inv_sel_o,
    output logic      [UNITS-1:0] cmp_pin_o,
    output logic      [UNITS-1:0] cmp_pin_oe_o,
    output logic      [UNITS-1:0] event_pulse_o,
    output logic      [1:0]       bandgap_tap_o,
    output logic                  ref_enable_o,
    output logic                  ref_out_en_o,
    output logic                  ref_range_o,
    output logic                  ref_supply_o,
    output logic      [3:0]       ref_level_o,
    output logic                  irq_o
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    tcc_unit_cfg_t    cfg [UNITS];
    tcc_ref_cfg_t     ref_cfg;
    logic             idle_halt;
    logic [UNITS-1:0] event_flag;
    logic [UNITS-1:0] compare_result;
    logic [UNITS-1:0] irq_stat;
    logic [UNITS-1:0] irq_mask;
    logic [UNITS-1:0] sync1;
    logic [UNITS-1:0] sync2;
    logic [UNITS-1:0] sync3;
    logic [UNITS-1:0] prev_result;
    logic [UNITS-1:0] next_event;
    logic [UNITS-1:0] running;
    logic [UNITS-1:0] unit_wr;
    logic             halted;

    assign halted = idle_halt & device_idle_i;

    // ----------------------------------------------------------------
    // per unit logic
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < UNITS; g++) begin : g_unit
            logic stable;
            logic rise;
            logic fall;
            logic evt_ok;
            assign unit_wr[g] = wr_i && (addr_i == `TCC_ADDR_UNIT1 + 8'(4 * g));
            assign running[g] = cfg[g].enable & ~halted;
            // only the agreeing second and third stages are looked at
            assign stable = (sync2[g] == sync3[g]);
            assign rise = stable & sync3[g] & ~prev_result[g];
            assign fall = stable & ~sync3[g] & prev_result[g];
            always_comb begin
                evt_ok = 1'b0;
                case (cfg[g].event_edge_select)
                    TCC_EDGE_ANY:  evt_ok = rise | fall;
                    // a raw fall is a falling result, or a rising one when inverted
                    TCC_EDGE_FALL: evt_ok = fall;
                    TCC_EDGE_RISE: evt_ok = rise;
                    default:       evt_ok = 1'b0;
                endcase
            end
            assign next_event[g] = evt_ok & running[g] & ~event_flag[g];

            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                end else begin
                    sync1[g] <= analog_cmp_i[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    prev_result[g] <= 1'b0;
                end else if (stable) begin
                    prev_result[g] <= sync3[g];
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    compare_result[g] <= 1'b0;
                end else if (running[g]) begin
                    compare_result[g] <= prev_result[g] ^ cfg[g].output_invert;
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    cfg[g] <= '0;
                end else if (unit_wr[g]) begin
                    cfg[g].enable              <= wdata_i[`TCC_UC_ENABLE];
                    cfg[g].out_en              <= wdata_i[`TCC_UC_OUT_EN];
                    cfg[g].output_invert       <= wdata_i[`TCC_UC_INVERT];
                    cfg[g].event_edge_select   <=
                        tcc_edge_t'(wdata_i[`TCC_UC_EDGE_HI:`TCC_UC_EDGE_LO]);
                    cfg[g].noninv_input_select <= wdata_i[`TCC_UC_NONINV];
                    cfg[g].inv_input_select    <=
                        tcc_inv_sel_t'(wdata_i[`TCC_UC_INV_HI:`TCC_UC_INV_LO]);
                end
            end

            // hardware set beats software write in the same cycle
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    event_flag[g] <= 1'b0;
                end else if (next_event[g]) begin
                    event_flag[g] <= 1'b1;
                end else if (unit_wr[g]) begin
                    event_flag[g] <= wdata_i[`TCC_UC_EVENT];
                end
            end

            assign noninv_sel_ref_o[g]     = cfg[g].noninv_input_select;
            assign noninv_use_ref_pin_o[g] =
                cfg[g].noninv_input_select & ref_cfg.ref_pin_select;
            assign inv_sel_o[2*g+1:2*g]    = cfg[g].inv_input_select;
            assign unit_enable_o[g]        = running[g];
            assign cmp_pin_o[g]            = compare_result[g];
            assign cmp_pin_oe_o[g]         = cfg[g].out_en & running[g];
        end
    endgenerate

    assign event_pulse_o = next_event;

    // ----------------------------------------------------------------
    // shared registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            idle_halt <= 1'b0;
        end else if (wr_i && addr_i == `TCC_ADDR_STATUS) begin
            idle_halt <= wdata_i[`TCC_ST_IDLE_HALT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ref_cfg <= '0;
        end else if (wr_i && addr_i == `TCC_ADDR_REF) begin
            ref_cfg <= tcc_ref_cfg_t'(wdata_i[`TCC_REF_PIN:`TCC_REF_LVL_LO]);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_mask <= `TCC_RESET_3;
        end else if (wr_i && addr_i == `TCC_ADDR_IRQ_MASK) begin
            irq_mask <= wdata_i[UNITS-1:0];
        end
    end

    // write one to clear, new event wins
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_stat <= `TCC_RESET_3;
        end else if (wr_i && addr_i == `TCC_ADDR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wdata_i[UNITS-1:0]) | next_event;
        end else begin
            irq_stat <= irq_stat | next_event;
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    assign bandgap_tap_o = ref_cfg.bandgap_tap_select;
    assign ref_enable_o  = ref_cfg.ref_enable;
    assign ref_out_en_o  = ref_cfg.ref_out_en;
    assign ref_range_o   = ref_cfg.ref_range_select;
    assign ref_supply_o  = ref_cfg.ref_supply_select;
    assign ref_level_o   = ref_cfg.ref_level_code;

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    function automatic logic [15:0] unit_word(input tcc_unit_cfg_t c,
                                              input logic evt,
                                              input logic res);
        logic [15:0] w;
        w = `TCC_RESET_16;
        w[`TCC_UC_ENABLE] = c.enable;
        w[`TCC_UC_OUT_EN] = c.out_en;
        w[`TCC_UC_INVERT] = c.output_invert;
        w[`TCC_UC_EVENT]  = evt;
        w[`TCC_UC_RESULT] = res;
        w[`TCC_UC_EDGE_HI:`TCC_UC_EDGE_LO] = c.event_edge_select;
        w[`TCC_UC_NONINV] = c.noninv_input_select;
        w[`TCC_UC_INV_HI:`TCC_UC_INV_LO] = c.inv_input_select;
        return w;
    endfunction

    logic [15:0] rd_word;
    always_comb begin
        rd_word = `TCC_RESET_16;
        if (addr_i == `TCC_ADDR_UNIT1) begin
            rd_word = unit_word(cfg[0], event_flag[0], compare_result[0]);
        end else if (addr_i == `TCC_ADDR_UNIT2) begin
            rd_word = unit_word(cfg[1], event_flag[1], compare_result[1]);
        end else if (addr_i == `TCC_ADDR_UNIT3) begin
            rd_word = unit_word(cfg[2], event_flag[2], compare_result[2]);
        end else if (addr_i == `TCC_ADDR_STATUS) begin
            rd_word[`TCC_ST_IDLE_HALT] = idle_halt;
            rd_word[`TCC_ST_EVT_LO +: UNITS] = event_flag;
            rd_word[UNITS-1:0] = compare_result;
        end else if (addr_i == `TCC_ADDR_REF) begin
            rd_word = 16'(ref_cfg) & `TCC_REF_MASK;
        end else if (addr_i == `TCC_ADDR_IRQ_STAT) begin
            rd_word[UNITS-1:0] = irq_stat;
        end else if (addr_i == `TCC_ADDR_IRQ_MASK) begin
            rd_word[UNITS-1:0] = irq_mask;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= {16'h0000, rd_word};
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_flag_blocks: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        event_flag != '0 |-> (next_event & event_flag) == '0)
        else $error("event raised while flag set");
    a_event_sets_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        next_event[0] |=> event_flag[0] && irq_stat[0])
        else $error("event did not set flag");
    a_none_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[0].event_edge_select == TCC_EDGE_NONE |-> !next_event[0])
        else $error("event with edge select off");
    a_rise_event: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[0].event_edge_select == TCC_EDGE_RISE && !cfg[0].output_invert
        && next_event[0] |-> sync3[0] && !prev_result[0])
        else $error("rise event on wrong edge");
    a_fall_event: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[0].event_edge_select == TCC_EDGE_FALL && !cfg[0].output_invert
        && next_event[0] |-> !sync3[0] && prev_result[0])
        else $error("fall event on wrong edge");
    a_result_sense: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        running[0] ##1 running[0] && $stable(cfg[0].output_invert)
        |-> compare_result[0] == ($past(prev_result[0]) ^ cfg[0].output_invert))
        else $error("result sense wrong");
    a_idle_halt: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        idle_halt && device_idle_i |-> unit_enable_o == '0 && next_event == '0)
        else $error("unit ran while halted");
    a_status_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rd_i && addr_i == `TCC_ADDR_STATUS |=> rdata_o[10:8] == $past(event_flag)
        && rdata_o[14:11] == 4'h0 && rdata_o[7:3] == 5'h00)
        else $error("status read wrong");
    a_ref_pin_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !cfg[0].noninv_input_select |-> !noninv_use_ref_pin_o[0])
        else $error("ref pin used without reference select");
    a_rise_inverted: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[0].event_edge_select == TCC_EDGE_RISE && cfg[0].output_invert
        && next_event[0] |-> sync3[0] && !prev_result[0])
        else $error("inverted rise event on wrong edge");
    a_fall_inverted: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[0].event_edge_select == TCC_EDGE_FALL && cfg[0].output_invert
        && next_event[0] |-> !sync3[0] && prev_result[0])
        else $error("inverted fall event on wrong edge");
    a_any_change: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[0].event_edge_select == TCC_EDGE_ANY && running[0] && !event_flag[0]
        && sync2[0] == sync3[0] && sync3[0] != prev_result[0] |-> next_event[0])
        else $error("change missed with edge select any");
    a_event_settled: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        next_event[0] |-> sync2[0] == sync3[0])
        else $error("event before input settled");
    a_event_single: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        next_event[0] |=> !next_event[0])
        else $error("one transition gave two events");
    a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        unit_wr[0] && !wdata_i[`TCC_UC_EVENT] && !next_event[0] |=> !event_flag[0])
        else $error("flag not cleared by software");
    a_irq_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_i && addr_i == `TCC_ADDR_IRQ_STAT && wdata_i[0] && !next_event[0]
        |=> !irq_stat[0])
        else $error("interrupt status not cleared");
    a_irq_raise: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        next_event[0] && irq_mask[0] && !(wr_i && addr_i == `TCC_ADDR_IRQ_MASK)
        |=> irq_o)
        else $error("unmasked event gave no interrupt");
    a_none_unit2: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[1].event_edge_select == TCC_EDGE_NONE |-> !next_event[1])
        else $error("unit 2 event with edge select off");
    a_none_unit3: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[2].event_edge_select == TCC_EDGE_NONE |-> !next_event[2])
        else $error("unit 3 event with edge select off");
    a_disabled_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !running[0] |-> !next_event[0])
        else $error("event while unit stopped");
    a_oe_stopped: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !running[0] |-> !cmp_pin_oe_o[0])
        else $error("pin driven while unit stopped");
    a_halt_freeze: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        halted |=> $stable(compare_result))
        else $error("result moved while halted");
    a_idle_runs: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !idle_halt && cfg[0].enable |-> unit_enable_o[0])
        else $error("unit stopped without idle halt");
    a_disabled_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !cfg[0].enable |=> $stable(compare_result[0]))
        else $error("result moved while disabled");
    a_status_ro: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_i && addr_i == `TCC_ADDR_STATUS && next_event == '0 |=> $stable(event_flag))
        else $error("status write changed an event flag");
    a_result_mirror: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rd_i && addr_i == `TCC_ADDR_STATUS |=> rdata_o[2:0] == $past(compare_result))
        else $error("status result bits wrong");
    a_unit_reserved: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rd_i && addr_i == `TCC_ADDR_UNIT1
        |=> rdata_o[3:2] == 2'h0 && rdata_o[31:16] == 16'h0000)
        else $error("unit reserved bits not zero");
    a_ref_reserved: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rd_i && addr_i == `TCC_ADDR_REF |=> rdata_o[15:11] == 5'h00)
        else $error("reference reserved bits not zero");
    a_ref_pin_on: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg[0].noninv_input_select && ref_cfg.ref_pin_select |-> noninv_use_ref_pin_o[0])
        else $error("ref pin select ignored");
    a_result_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rd_i && addr_i == `TCC_ADDR_UNIT1 |=> rdata_o[8] == $past(compare_result[0]))
        else $error("unit result bit wrong");
    a_flag_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        rd_i && addr_i == `TCC_ADDR_UNIT1 |=> rdata_o[9] == $past(event_flag[0]))
        else $error("unit event bit wrong");
endmodule
`default_nettype wire

// [hdl/tcc_regs.svh]
// register offsets, field positions and reset values of the comparator control block
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
`define TCC_ADDR_UNIT1     8'h00
`define TCC_ADDR_UNIT2     8'h04
`define TCC_ADDR_UNIT3     8'h08
`define TCC_ADDR_STATUS    8'h0c
`define TCC_ADDR_REF       8'h10
`define TCC_ADDR_IRQ_STAT  8'h14
`define TCC_ADDR_IRQ_MASK  8'h18
`define TCC_ADDR_IDLE      8'h1c
`define TCC_UC_ENABLE      15
`define TCC_UC_OUT_EN      14
`define TCC_UC_INVERT      13
`define TCC_UC_EVENT       9
`define TCC_UC_RESULT      8
`define TCC_UC_EDGE_HI     7
`define TCC_UC_EDGE_LO     6
`define TCC_UC_NONINV      4
`define TCC_UC_INV_HI      1
`define TCC_UC_INV_LO      0
`define TCC_ST_IDLE_HALT   15
`define TCC_ST_EVT_LO      8
`define TCC_REF_MASK       16'h07ff
`define TCC_REF_PIN        10
`define TCC_REF_TAP_HI     9
`define TCC_REF_TAP_LO     8
`define TCC_REF_RANGE      5
`define TCC_REF_SUPPLY     4
`define TCC_REF_LVL_HI     3
`define TCC_REF_LVL_LO     0
`define TCC_RESET_16       16'h0000
`define TCC_RESET_3        3'h0
`endif

// [hdl/tcc_pkg.sv]
// types shared by the comparator control block
`default_nettype none
package tcc_pkg;
    typedef enum logic [1:0] {
        TCC_EDGE_NONE = 2'b00,
        TCC_EDGE_RISE = 2'b01,
        TCC_EDGE_FALL = 2'b10,
        TCC_EDGE_ANY  = 2'b11
    } tcc_edge_t;
    typedef enum logic [1:0] {
        TCC_INV_PIN_B = 2'b00,
        TCC_INV_PIN_C = 2'b01,
        TCC_INV_PIN_D = 2'b10,
        TCC_INV_REF   = 2'b11
    } tcc_inv_sel_t;
    typedef struct packed {
        logic         enable;
        logic         out_en;
        logic         output_invert;
        tcc_edge_t    event_edge_select;
        logic         noninv_input_select;
        tcc_inv_sel_t inv_input_select;
    } tcc_unit_cfg_t;
    typedef struct packed {
        logic       ref_pin_select;
        logic [1:0] bandgap_tap_select;
        logic       ref_enable;
        logic       ref_out_en;
        logic       ref_range_select;
        logic       ref_supply_select;
        logic [3:0] ref_level_code;
    } tcc_ref_cfg_t;
endpackage
`default_nettype wire

// [testbench/tcc_cmp_model.sv]
// behavioural model of the three analog comparators and their input pins
`timescale 1ns/1ps
`default_nettype none
module tcc_cmp_model (
    input  wire logic [2:0]      sel_ref_i,
    input  wire logic [5:0]      inv_sel_i,
    input  wire logic [5:0][7:0] lvl_i,
    output logic      [2:0]      cmp_o
);
    // levels: 0 pin a, 1 pin b, 2 pin c, 3 pin d, 4 bandgap tap, 5 reference
    always_comb begin
        for (int u = 0; u < 3; u++) begin
            cmp_o[u] = (sel_ref_i[u] ? lvl_i[5] : lvl_i[0]) > lvl_i[1 + inv_sel_i[2*u +: 2]];
        end
    end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"
module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic            sys_clk_i, reset_i, wr_i, rd_i, device_idle_i;
    logic [7:0]      addr_i;
    logic [31:0]     wdata_i, rdata_o, d;
    logic [2:0]      analog_cmp_i, unit_enable_o, noninv_sel_ref_o, noninv_use_ref_pin_o;
    logic [2:0]      cmp_pin_o, cmp_pin_oe_o, event_pulse_o;
    logic [5:0]      inv_sel_o;
    logic [1:0]      bandgap_tap_o;
    logic [3:0]      ref_level_o;
    logic            ref_enable_o, ref_out_en_o, ref_range_o, ref_supply_o, irq_o;
    logic [5:0][7:0] lvl;
    logic            e, rf, fl, ms;
    int              num_errors = 0;
    int              tests_run = 0;
    int              ev_cnt = 0;
    int              n0;

    tcc_core i_dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .device_idle_i(device_idle_i),
        .analog_cmp_i(analog_cmp_i), .unit_enable_o(unit_enable_o),
        .noninv_sel_ref_o(noninv_sel_ref_o), .noninv_use_ref_pin_o(noninv_use_ref_pin_o),
        .inv_sel_o(inv_sel_o), .cmp_pin_o(cmp_pin_o), .cmp_pin_oe_o(cmp_pin_oe_o),
        .event_pulse_o(event_pulse_o), .bandgap_tap_o(bandgap_tap_o),
        .ref_enable_o(ref_enable_o), .ref_out_en_o(ref_out_en_o), .ref_range_o(ref_range_o),
        .ref_supply_o(ref_supply_o), .ref_level_o(ref_level_o), .irq_o(irq_o)
    );
    tcc_cmp_model i_model (
        .sel_ref_i(noninv_sel_ref_o), .inv_sel_i(inv_sel_o), .lvl_i(lvl), .cmp_o(analog_cmp_i)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (!reset_i && event_pulse_o[0]) ev_cnt <= ev_cnt + 1;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkreg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic settle;
        repeat (8) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [7:0] ua(input int u);
        return 8'(`TCC_ADDR_UNIT1 + 4 * u);
    endfunction
    initial begin
        repeat (50000) @(posedge sys_clk_i);
        num_errors++;
        $display("CHECK FAILED t=%0t run did not complete", $time);
        tally_and_finish;
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        reset_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        device_idle_i = 1'b0;
        lvl = {8'd200, 8'd150, 8'd50, 8'd150, 8'd50, 8'd100};
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 32; a += 4) chkreg(8'(a), 32'h0);
        wr(`TCC_ADDR_UNIT1, 32'h7fff);
        chkreg(`TCC_ADDR_UNIT1, 32'h62d3);
        wr(`TCC_ADDR_UNIT1, 32'h0);
        wr(`TCC_ADDR_STATUS, 32'hffff);
        chkreg(`TCC_ADDR_STATUS, 32'h8000);
        wr(`TCC_ADDR_STATUS, 32'h0);
        wr(`TCC_ADDR_REF, 32'hffff);
        chkreg(`TCC_ADDR_REF, 32'h07ff);
        wr(`TCC_ADDR_IDLE, 32'hffff);
        chkreg(`TCC_ADDR_IDLE, 32'h0);
        for (int t = 0; t < 4; t++) begin
            wr(`TCC_ADDR_REF, (t << 8) | (t[0] << 7) | (t[1] << 6) | (t[0] << 5)
               | (t[1] << 4) | (t * 5));
            settle;
            chk({bandgap_tap_o, ref_enable_o, ref_out_en_o, ref_range_o, ref_supply_o,
                 ref_level_o}, {t[1:0], t[0], t[1], t[0], t[1], 4'(t * 5)});
        end
        wr(`TCC_ADDR_REF, 32'h0400);
        for (int u = 0; u < 3; u++) begin
            for (int k = 0; k < 16; k++) begin
                // k: inverting select, non-inverting select, invert
                wr(ua(u), 32'hc000 | (k[3] << 13) | (k[2] << 4) | k[1:0]);
                settle;
                e = ((k[2] ? lvl[5] : lvl[0]) > lvl[1 + k[1:0]]) ^ k[3];
                chk({unit_enable_o[u], cmp_pin_oe_o[u], noninv_sel_ref_o[u], noninv_use_ref_pin_o[u], inv_sel_o[2*u +: 2], cmp_pin_o[u]}, {2'b11, k[2], k[2], k[1:0], e});
                rd(`TCC_ADDR_STATUS, d);
                chk(d[u], e);
            end
        end
        for (int k = 0; k < 8; k++) begin
            // k: edge select, invert; mask only while not inverted
            ms = !k[2];
            rf = (k[1:0] == 2'b01) || (k[1:0] == 2'b11);
            fl = rf || (k[1:0] == 2'b10);
            wr(`TCC_ADDR_IRQ_MASK, 32'(ms));
            lvl[1] <= 8'd150;
            settle;
            wr(ua(0), 32'h8000 | (k[2] << 13) | (k[1:0] << 6));
            settle;
            wr(`TCC_ADDR_IRQ_STAT, 32'h7);
            settle;
            n0 = ev_cnt;
            lvl[1] <= 8'd50;
            settle;
            chk(ev_cnt - n0, 32'(rf));
            chk(irq_o, rf & ms);
            chkreg(ua(0), 32'h8000 | (k[2] << 13) | (rf << 9) | (!k[2] << 8) | (k[1:0] << 6));
            lvl[1] <= 8'd150;
            settle;
            chk(ev_cnt - n0, 32'(fl));
            rd(`TCC_ADDR_STATUS, d);
            chk(d[8], fl);
            chkreg(`TCC_ADDR_IRQ_STAT, 32'(fl));
            chk(irq_o, fl & ms);
            wr(`TCC_ADDR_IRQ_STAT, 32'h1);
            settle;
            chk(irq_o, 1'b0);
        end
        wr(`TCC_ADDR_STATUS, 32'h8000);
        settle;
        chk(unit_enable_o, 3'b111);
        @(posedge sys_clk_i);
        device_idle_i <= 1'b1;
        settle;
        chk(unit_enable_o, 3'b000);
        wr(`TCC_ADDR_STATUS, 32'h0);
        settle;
        chk(unit_enable_o, 3'b111);
        tally_and_finish;
    end
endmodule
`default_nettype wire
